// file: design/nfh_host.v
`include "nfh_defines.vh"

module nfh_host #(
    parameter AW        = `NFH_ADDR_W,
    parameter ACC_CYC   = `NFH_ACC_CYC,
    parameter PAGE_CYC  = `NFH_PAGE_CYC,
    parameter RST_LOW   = `NFH_RST_LOW_CYC,
    parameter RST_WAIT  = `NFH_RST_READ_CYC,
    parameter ABORT_CYC = `NFH_ABORT_CYC
) (
    // clock and reset
    input  wire          clock,
    input  wire          rst_n,
    // user command port
    input  wire          cmd_valid,
    input  wire [1:0]    cmd_op,
    input  wire [AW-1:0] cmd_addr,
    input  wire [15:0]   cmd_wdata,
    input  wire          cmd_byte_mode,
    input  wire          cmd_keep_sel,
    output reg           cmd_ready,
    output reg           rsp_valid,
    output reg  [15:0]   rsp_rdata,
    // flash pins
    output reg  [AW-1:0] fl_addr,
    output reg           fl_sel_n,
    output reg           fl_oe_n,
    output reg           fl_we_n,
    output reg           fl_rst_n,
    output reg           fl_wp,
    output reg           fl_word,
    output reg  [15:0]   fl_dq_o,
    output reg  [15:0]   fl_dq_oe,
    input  wire [15:0]   fl_dq_i,
    input  wire          fl_busy_n
);
    localparam S_RST  = 3'h0;
    localparam S_WAKE = 3'h1;
    localparam S_IDLE = 3'h2;
    localparam S_RD   = 3'h3;
    localparam S_WSET = 3'h4;
    localparam S_WPUL = 3'h5;
    localparam S_WHLD = 3'h6;
    localparam CW     = 16;

    reg [2:0]    state_ff, nxt_state;
    reg [CW-1:0] cnt_ff, nxt_cnt;
    reg          pg_ok_ff, nxt_pg_ok;
    reg [AW-1:0] pg_addr_ff, nxt_pg_addr;
    reg          nxt_ready, nxt_rvalid;
    reg [15:0]   nxt_rdata;
    reg [AW-1:0] nxt_addr;
    reg          nxt_sel_n, nxt_oe_n, nxt_we_n, nxt_frst_n, nxt_wp, nxt_word;
    reg [15:0]   nxt_dq_o, nxt_dq_oe;
    wire [15:0]  dq_s;
    wire         busy_s;

    // pins from outside our domain pass two flops before use
    nfh_sync2 #(.W(17)) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({fl_busy_n, fl_dq_i}),
        .q     ({busy_s, dq_s})
    );

    // page tag compares everything above the in-page word bits
    wire same_page = pg_ok_ff &&
        (cmd_addr[AW-1:`NFH_PAGE_BITS] == pg_addr_ff[AW-1:`NFH_PAGE_BITS]);
    // two sync stages delay data; add them to the wait
    localparam integer  ACC_SUM  = ACC_CYC + 2;
    localparam integer  PAGE_SUM = PAGE_CYC + 2;
    localparam integer  SET_SUM  = `NFH_SETUP_CYC;
    localparam integer  PUL_SUM  = `NFH_WPULSE_CYC;
    localparam [CW-1:0] ACC_W    = ACC_SUM[CW-1:0];
    localparam [CW-1:0] PAGE_W   = PAGE_SUM[CW-1:0];
    localparam [CW-1:0] SETUP_W  = SET_SUM[CW-1:0];
    localparam [CW-1:0] PULSE_W  = PUL_SUM[CW-1:0];

    always @* begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_pg_ok   = pg_ok_ff;
        nxt_pg_addr = pg_addr_ff;
        nxt_ready   = 1'b0;
        nxt_rvalid  = 1'b0;
        nxt_rdata   = rsp_rdata;
        nxt_addr    = fl_addr;
        nxt_sel_n   = fl_sel_n;
        nxt_oe_n    = fl_oe_n;
        nxt_we_n    = fl_we_n;
        nxt_frst_n  = fl_rst_n;
        nxt_wp      = fl_wp;
        nxt_word    = fl_word;
        nxt_dq_o    = fl_dq_o;
        nxt_dq_oe   = fl_dq_oe;
        case (state_ff)
            S_RST: begin
                // reset held low; a reset command adds ABORT_CYC to cover an in-flight abort, power-on holds RST_LOW only
                nxt_frst_n = 1'b0;
                nxt_sel_n  = 1'b1;
                nxt_oe_n   = 1'b1;
                nxt_we_n   = 1'b1;
                nxt_dq_oe  = 16'h0000;
                nxt_pg_ok  = 1'b0;
                if (cnt_ff == 0) begin
                    nxt_frst_n = 1'b1;
                    nxt_cnt    = RST_WAIT[CW-1:0];
                    nxt_state  = S_WAKE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            S_WAKE: begin
                // no access before reset-to-read/write delay elapses
                if (cnt_ff == 0) begin
                    nxt_state = S_IDLE;
                    nxt_ready = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            S_IDLE: begin
                nxt_ready = 1'b1;
                if (cmd_valid && cmd_ready) begin
                    nxt_ready = 1'b0;
                    nxt_word  = ~cmd_byte_mode;
                    nxt_addr  = cmd_addr;
                    case (cmd_op)
                        `NFH_CMD_READ: begin
                            nxt_we_n  = 1'b1;
                            nxt_dq_oe = 16'h0000;
                            nxt_sel_n = 1'b0;
                            nxt_oe_n  = 1'b0;
                            // in byte mode top data line carries address lsb
                            if (cmd_byte_mode) begin
                                nxt_dq_o  = {cmd_wdata[15], 15'h0000};
                                nxt_dq_oe = 16'h8000;
                            end
                            if (!fl_sel_n && same_page &&
                                fl_word == ~cmd_byte_mode)
                                nxt_cnt = PAGE_W;
                            else
                                nxt_cnt = ACC_W;
                            nxt_state = S_RD;
                        end
                        `NFH_CMD_WRITE: begin
                            nxt_oe_n  = 1'b1;
                            nxt_wp    = 1'b1;
                            nxt_sel_n = 1'b0;
                            nxt_pg_ok = 1'b0;
                            nxt_dq_o  = cmd_wdata;
                            nxt_dq_oe = cmd_byte_mode ? 16'h80ff : 16'hffff;
                            nxt_cnt   = SETUP_W;
                            nxt_state = S_WSET;
                        end
                        `NFH_CMD_RESET: begin
                            nxt_cnt   = RST_LOW[CW-1:0] +
                                        ABORT_CYC[CW-1:0];
                            nxt_state = S_RST;
                        end
                        default: begin
                            // unknown op leaves the pins untouched
                            nxt_ready = 1'b1;
                            nxt_word  = fl_word;
                            nxt_addr  = fl_addr;
                        end
                    endcase
                end
            end
            S_RD: begin
                if (cnt_ff == 0) begin
                    nxt_rdata   = fl_word ? dq_s : {8'h00, dq_s[7:0]};
                    nxt_rvalid  = 1'b1;
                    nxt_pg_ok   = 1'b1;
                    nxt_pg_addr = fl_addr;
                    nxt_ready   = 1'b1;
                    nxt_state   = S_IDLE;
                    if (!cmd_keep_sel) begin
                        // standby releases the bus; next read is random
                        nxt_sel_n = 1'b1;
                        nxt_oe_n  = 1'b1;
                        nxt_pg_ok = 1'b0;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            S_WSET: begin
                // strobe falls after select so address latches on it
                if (cnt_ff == 0) begin
                    nxt_we_n  = 1'b0;
                    nxt_cnt   = PULSE_W;
                    nxt_state = S_WPUL;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            S_WPUL: begin
                // pulse well above glitch width so it is never filtered
                if (cnt_ff == 0) begin
                    nxt_we_n  = 1'b1;
                    nxt_cnt   = SETUP_W;
                    nxt_state = S_WHLD;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            S_WHLD: begin
                // data held past strobe rise; flash keeps working alone
                if (cnt_ff == 0) begin
                    nxt_sel_n = 1'b1;
                    nxt_dq_oe = 16'h0000;
                    nxt_rvalid = 1'b1;
                    nxt_ready = 1'b1;
                    nxt_state = S_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= S_RST;
            cnt_ff     <= RST_LOW[CW-1:0];
            pg_ok_ff   <= 1'b0;
            pg_addr_ff <= {AW{1'b0}};
            cmd_ready  <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_rdata  <= 16'h0000;
            fl_addr    <= {AW{1'b0}};
            fl_sel_n   <= 1'b1;
            fl_oe_n    <= 1'b1;
            fl_we_n    <= 1'b1;
            fl_rst_n   <= 1'b0;
            fl_wp      <= 1'b1;
            fl_word    <= 1'b1;
            fl_dq_o    <= 16'h0000;
            fl_dq_oe   <= 16'h0000;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            pg_ok_ff   <= nxt_pg_ok;
            pg_addr_ff <= nxt_pg_addr;
            cmd_ready  <= nxt_ready;
            rsp_valid  <= nxt_rvalid;
            rsp_rdata  <= nxt_rdata;
            fl_addr    <= nxt_addr;
            fl_sel_n   <= nxt_sel_n;
            fl_oe_n    <= nxt_oe_n;
            fl_we_n    <= nxt_we_n;
            fl_rst_n   <= nxt_frst_n;
            fl_wp      <= nxt_wp;
            fl_word    <= nxt_word;
            fl_dq_o    <= nxt_dq_o;
            fl_dq_oe   <= nxt_dq_oe;
        end
    end
endmodule

// file: design/nfh_sync2.v
module nfh_sync2 #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst_n,
    // data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

// file: pkg/nfh_defines.vh
`ifndef NFH_DEFINES_VH
`define NFH_DEFINES_VH

// bus geometry
`define NFH_ADDR_W        26
`define NFH_DATA_W        16
`define NFH_PAGE_BITS     4
`define NFH_BLK_SHIFT_X16 16
`define NFH_BLK_SHIFT_X8  17
`define NFH_BLK_IDX_W     10

// timing in ns, clock period in ns
`define NFH_CLK_NS        10
`define NFH_ACC_NS        110
`define NFH_PAGE_NS       20
`define NFH_SETUP_NS      10
`define NFH_WPULSE_NS     40
`define NFH_RST_LOW_NS    500
`define NFH_RST_READ_NS   200
`define NFH_RST_WRITE_NS  200
`define NFH_ABORT_NS      50000

// cycle counts, least times rounded up
`define NFH_CYC(ns) (((ns) + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_ACC_CYC      `NFH_CYC(`NFH_ACC_NS)
`define NFH_PAGE_CYC     `NFH_CYC(`NFH_PAGE_NS)
`define NFH_SETUP_CYC    `NFH_CYC(`NFH_SETUP_NS)
`define NFH_WPULSE_CYC   `NFH_CYC(`NFH_WPULSE_NS)
`define NFH_RST_LOW_CYC  `NFH_CYC(`NFH_RST_LOW_NS)
`define NFH_RST_READ_CYC `NFH_CYC(`NFH_RST_READ_NS)
`define NFH_RST_WR_CYC   `NFH_CYC(`NFH_RST_WRITE_NS)
`define NFH_ABORT_CYC    `NFH_CYC(`NFH_ABORT_NS)

// command codes
`define NFH_CMD_READ     2'h0
`define NFH_CMD_WRITE    2'h1
`define NFH_CMD_RESET    2'h2

`endif

// file: verification/nfh_flash_model.sv
module nfh_flash_model #(
    parameter ACC  = 11,
    parameter PAGE = 2
) (
    // clock used only to measure access times
    input wire         clock,
    // pins from the host
    input wire [25:0]  fl_addr,
    input wire         fl_sel_n,
    input wire         fl_oe_n,
    input wire         fl_we_n,
    input wire         fl_rst_n,
    input wire         fl_wp,
    input wire         fl_word,
    input wire [15:0]  fl_dq_o,
    // data returned
    output logic [15:0] m_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:63];
    logic [29:0] key_ff;
    logic [7:0]  age_ff = 8'h00;
    logic        hit_ff = 1'b0;
    logic [25:0] wa;
    wire  [29:0] key = {fl_word, !fl_word && fl_dq_o[15], fl_oe_n,
                        fl_sel_n, fl_addr};
    // lowest 64 words stored, rest of the map is a fixed pattern
    wire  [15:0] w = fl_addr[25:6] == 20'h0 ?
                     mem[fl_addr[5:0]] :
                     fl_addr[15:0] ^ {6'h0, fl_addr[25:16]} ^ 16'h5a3c;
    wire ok = fl_rst_n && !fl_sel_n && !fl_oe_n &&
              key == key_ff &&
              age_ff >= (hit_ff ? PAGE - 1 : ACC - 1);
    initial for (int i = 0; i < 64; i++) mem[i] = 16'h5a3c ^ i[15:0];
    always @(posedge clock) begin
        key_ff <= key;
        if (key != key_ff) begin
            age_ff <= 8'h00;
            hit_ff <= key[29] == key_ff[29] && key[27:26] == 2'h0 &&
                      key_ff[27:26] == 2'h0 &&
                      key[25:4] == key_ff[25:4];
        end else begin
            age_ff <= age_ff + {7'h0, ~&age_ff};
        end
    end
    // released lines show inverted data, never the stale value
    always @* begin
        if (!ok)
            m_dq = ~w;
        else if (fl_word)
            m_dq = w;
        else
            m_dq = {~w[15:8], fl_dq_o[15] ? w[15:8] : w[7:0]};
    end
    always @(negedge fl_we_n or negedge fl_sel_n)
        if (!fl_we_n && !fl_sel_n) wa = fl_addr;
    always @(posedge fl_we_n or posedge fl_sel_n)
        if (fl_we_n != fl_sel_n && fl_wp && fl_rst_n && wa[25:6] == 20'h0)
            mem[wa[5:0]] = fl_dq_o;
endmodule

// file: verification/nfh_host_monitor.sv
module nfh_host_monitor #(
    parameter AW       = 26,
    parameter RST_LOW  = 50,
    parameter RST_WAIT = 20
) (
    // clock and reset
    input wire          clock,
    input wire          rst_n,
    // host outputs
    input wire          rsp_valid,
    input wire [AW-1:0] fl_addr,
    input wire          fl_sel_n,
    input wire          fl_oe_n,
    input wire          fl_we_n,
    input wire          fl_rst_n,
    input wire          fl_wp,
    input wire [15:0]   fl_dq_o,
    input wire [15:0]   fl_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles flash reset was held low, and cycles since it was let go
    logic [7:0] low_ff;
    logic [7:0] up_ff;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_ff <= 8'h00;
            up_ff  <= 8'h00;
        end else begin
            low_ff <= fl_rst_n ? 8'h00 : low_ff + {7'h0, ~&low_ff};
            up_ff  <= !fl_rst_n ? 8'h00 : up_ff + {7'h0, ~&up_ff};
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_wr_oe_high: assert property (
        !fl_we_n |-> fl_oe_n && !fl_sel_n) else $error("oe low in write");
    a_wp_high: assert property (
        fl_wp) else $error("protect pin low");
    a_wr_data_on: assert property (
        !fl_we_n |-> fl_dq_oe[7:0] == 8'hff) else $error("data not driven");
    a_wr_addr_hold: assert property (
        !fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_o))
        else $error("address or data moved under strobe");
    a_wr_data_end: assert property (
        $rose(fl_we_n) |-> !fl_sel_n && $stable(fl_dq_o))
        else $error("data or select gone at strobe rise");
    a_rd_no_drive: assert property (
        !fl_oe_n |-> fl_we_n && fl_dq_oe[14:0] == 15'h0)
        else $error("host drives data during read");
    a_rd_random: assert property (
        $fell(fl_oe_n) |-> !rsp_valid[*8] ##1 !rsp_valid[*3]
        ##[1:12] rsp_valid) else $error("random read timing wrong");
    a_page_min: assert property (
        $changed(fl_addr) && !fl_oe_n && !$past(fl_oe_n) |->
        !rsp_valid[*2]) else $error("page read sampled too early");
    a_rst_quiet: assert property (
        !fl_rst_n |-> fl_sel_n && fl_oe_n && fl_we_n)
        else $error("bus active while flash in reset");
    a_rst_low: assert property (
        $rose(fl_rst_n) |-> low_ff >= RST_LOW - 1)
        else $error("flash reset pulse too short");
    a_rst_wait: assert property (
        !fl_sel_n |-> up_ff >= RST_WAIT) else $error("access too soon");
endmodule

bind nfh_host nfh_host_monitor #(
    .AW(AW), .RST_LOW(RST_LOW), .RST_WAIT(RST_WAIT)
) u_mon (
    .clock, .rst_n, .rsp_valid, .fl_addr, .fl_sel_n, .fl_oe_n,
    .fl_we_n, .fl_rst_n, .fl_wp, .fl_dq_o, .fl_dq_oe
);

// file: verification/nfh_host_tb.sv
module nfh_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam ACC = 11;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [1:0]  cmd_op = 2'h0;
    logic [25:0] cmd_addr = 26'h0;
    logic [15:0] cmd_wdata = 16'h0;
    logic        cmd_byte_mode = 1'b0;
    logic        cmd_keep_sel = 1'b0;
    wire         cmd_ready, rsp_valid, fl_sel_n, fl_oe_n, fl_we_n;
    wire         fl_rst_n, fl_wp, fl_word;
    wire  [15:0] rsp_rdata, fl_dq_o, fl_dq_oe, m_dq;
    wire  [25:0] fl_addr;
    wire  [15:0] fl_dq_i = (fl_dq_o & fl_dq_oe) | (m_dq & ~fl_dq_oe);
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          lat;
    logic [15:0] rd;
    nfh_host #(.ABORT_CYC(4)) dut (.clock, .rst_n, .cmd_valid, .cmd_op,
        .cmd_addr, .cmd_wdata, .cmd_byte_mode, .cmd_keep_sel, .cmd_ready,
        .rsp_valid, .rsp_rdata, .fl_addr, .fl_sel_n, .fl_oe_n, .fl_we_n,
        .fl_rst_n, .fl_wp, .fl_word, .fl_dq_o, .fl_dq_oe, .fl_dq_i,
        .fl_busy_n(1'b1));
    nfh_flash_model flash (.clock, .fl_addr, .fl_sel_n, .fl_oe_n,
        .fl_we_n, .fl_rst_n, .fl_wp, .fl_word, .fl_dq_o, .m_dq);
    always #5 clock = ~clock;
    ////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] pat(input logic [25:0] a);
        return a[15:0] ^ {6'h0, a[25:16]} ^ 16'h5a3c;
    endfunction
    task automatic run(input logic [1:0] op, input logic [25:0] a,
                       input logic [15:0] wd, input logic bm, ks);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= wd;
        cmd_byte_mode <= bm;
        cmd_keep_sel <= ks;
        do @(posedge clock); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        lat = 0;
        if (op == 2'h2) begin
            do @(posedge clock); while (cmd_ready !== 1'b1);
        end else begin
            do begin
                @(posedge clock);
                lat++;
            end while (rsp_valid !== 1'b1);
        end
        rd = rsp_rdata;
    endtask
    ////////////////////////////////////////
    task automatic t_random;
        run(2'h0, 26'h3ff_ffff, 16'h0, 1'b0, 1'b0);
        check(rd, pat(26'h3ff_ffff));
        check({15'h0, lat > ACC}, 16'h1);
        run(2'h0, 26'h001_0000, 16'h0, 1'b0, 1'b0);
        check(rd, pat(26'h001_0000));
        $display("random read test done");
    endtask
    task automatic t_page;
        run(2'h0, 26'h20, 16'h0, 1'b0, 1'b1);
        check(rd, pat(26'h20));
        run(2'h0, 26'h2f, 16'h0, 1'b0, 1'b1);
        check(rd, pat(26'h2f));
        check({15'h0, lat < ACC}, 16'h1);
        run(2'h0, 26'h30, 16'h0, 1'b0, 1'b0);
        check(rd, pat(26'h30));
        check({15'h0, lat > ACC}, 16'h1);
        $display("page read test done");
    endtask
    task automatic t_write;
        run(2'h1, 26'h7, 16'hc0de, 1'b0, 1'b0);
        run(2'h0, 26'h7, 16'h0, 1'b0, 1'b0);
        check(rd, 16'hc0de);
        run(2'h0, 26'h6, 16'h0, 1'b0, 1'b0);
        check(rd, pat(26'h6));
        check({15'h0, fl_wp}, 16'h1);
        $display("write test done");
    endtask
    task automatic t_byte;
        run(2'h0, 26'h7, 16'h8000, 1'b1, 1'b0);
        check(rd, 16'h00c0);
        check({15'h0, fl_word}, 16'h0);
        run(2'h0, 26'h7, 16'h0, 1'b1, 1'b0);
        check(rd, 16'h00de);
        $display("byte mode test done");
    endtask
    task automatic t_reset;
        run(2'h2, 26'h0, 16'h0, 1'b0, 1'b0);
        run(2'h0, 26'h5, 16'h0, 1'b0, 1'b0);
        check(rd, pat(26'h5));
        $display("flash reset test done");
    endtask
    task automatic t_ignore;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_op <= 2'h3;
        cmd_addr <= 26'h15;
        @(posedge clock);
        cmd_valid <= 1'b0;
        repeat (3) begin
            @(posedge clock);
            check({15'h0, rsp_valid}, 16'h0);
        end
        check({15'h0, cmd_ready & fl_sel_n}, 16'h1);
        check(fl_addr[15:0], 16'h0005);
        $display("ignored command test done");
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        do @(posedge clock); while (cmd_ready !== 1'b1);
        t_random;
        t_page;
        t_write;
        t_byte;
        t_reset;
        t_ignore;
        give_verdict;
    end
endmodule
